/* rtl/pch_pkg.sv */
// Shared constants and types for the configuration header and status block
package pch_pkg;

	// Configuration address decode
	localparam logic [3:0] CMD_CFG_READ     = 4'hA;
	localparam logic [3:0] CMD_CFG_WRITE    = 4'hB;
	localparam logic [1:0] ADDR_TYPE0       = 2'h0;
	localparam logic [2:0] FUNC_ZERO        = 3'h0;
	localparam int         ADDR_IDX_LSB     = 2;
	localparam int         ADDR_IDX_MSB     = 7;
	localparam int         ADDR_FUNC_LSB    = 8;
	localparam int         ADDR_FUNC_MSB    = 10;

	// Byte offsets and doubleword indices of the header words
	localparam logic [7:0] OFS_MAKER_ID     = 8'h00;
	localparam logic [7:0] OFS_CHIP_ID      = 8'h02;
	localparam logic [7:0] OFS_COMMAND      = 8'h04;
	localparam logic [7:0] OFS_STATUS       = 8'h06;
	localparam logic [7:0] OFS_CAP_POINTER  = 8'h34;
	localparam logic [5:0] IDX_IDENT        = 6'h00;
	localparam logic [5:0] IDX_CMD_STATUS   = 6'h01;

	// Command word layout
	localparam logic [15:0] CMD_WRITE_MASK  = 16'h0137;
	localparam logic [15:0] CMD_RESET       = 16'h0000;
	localparam int          CMD_IO_SPACE    = 0;
	localparam int          CMD_MEM_SPACE   = 1;
	localparam int          CMD_BUS_MASTER  = 2;
	localparam int          CMD_SYS_ERR_DRV = 8;

	// Status word layout, bit positions within the doubleword
	localparam int          STAT_SYS_ERR    = 30;
	localparam int          STAT_MST_ABORT  = 29;
	localparam int          STAT_TGT_ABORT  = 28;
	localparam int          STAT_FLAG_LSB   = 28;
	localparam int          STAT_FLAG_MSB   = 30;
	localparam logic [1:0]  DECODE_FAST     = 2'h0;
	localparam logic [1:0]  DECODE_MEDIUM   = 2'h1;
	localparam logic        CAP_PRESENT     = 1'h1;
	localparam logic [2:0]  FLAGS_RESET     = 3'h0;
	localparam int          FLAG_COUNT      = 3;

	// Strap capture: cycles for the sampling chain to fill after reset
	localparam logic [1:0]  STRAP_FILL      = 2'h3;

	// Target sequencer
	typedef enum logic [1:0] {
		PCH_IDLE   = 2'b00,
		PCH_DECODE = 2'b01,
		PCH_ACK    = 2'b10,
		PCH_TURN   = 2'b11
	} pch_state_t;

endpackage

/* rtl/pch_strap.sv */
// Bus-speed strap sampler, caught once after reset release
`timescale 1ns/100ps
module pch_strap (
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic strap_pin,
	output logic      fast_bus_capable
);
	logic       s1_q, s2_q, s3_q;
	logic [1:0] fill_q;
	logic       done_q;
	logic       cap_q;
	logic       take;

	// Capture only once the chain has filled and the last two stages agree
	assign take = !done_q && (fill_q == pch_pkg::STRAP_FILL) && (s2_q == s3_q);

	// Sampling chain; the strap is a board level, not on our clock
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			s1_q   <= 1'h0;
			s2_q   <= 1'h0;
			s3_q   <= 1'h0;
			fill_q <= 2'h0;
			done_q <= 1'h0;
			cap_q  <= 1'h0;
		end else begin
			s1_q <= strap_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (fill_q != pch_pkg::STRAP_FILL) begin
				fill_q <= fill_q + 2'h1;
			end
			if (take) begin
				done_q <= 1'h1;
				cap_q  <= s3_q;
			end
		end
	end

	assign fast_bus_capable = cap_q;
endmodule

/* rtl/pch_sticky.sv */
// Sticky error flags, set by events and cleared by writing one
`timescale 1ns/100ps
module pch_sticky (
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic [2:0] set,
	input  wire logic [2:0] clr,
	output logic      [2:0] flags
);
	logic [2:0] flag_q;
	logic [2:0] flag_d;

	genvar i;
	generate
		for (i = 0; i < pch_pkg::FLAG_COUNT; i++) begin : g_flag
			// Set wins so an event landing on the clear is not lost
			assign flag_d[i] = set[i] | (flag_q[i] & ~clr[i]);
		end
	endgenerate

	// Flag storage
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			flag_q <= pch_pkg::FLAGS_RESET;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign flags = flag_q;
endmodule

/* rtl/pch_config_header.sv */
// Configuration header target: identification, command and status words
`timescale 1ns/100ps
module pch_config_header #(
	parameter logic [15:0] CHIP_NUMBER = 16'h0A5C, // Arbitrary value
	parameter logic [15:0] MAKER_CODE  = 16'h5A3E  // Arbitrary value
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        idsel,
	input  wire logic        frame_b_i,
	input  wire logic        irdy_b_i,
	input  wire logic [3:0]  cbe_b_i,
	input  wire logic [31:0] ad_i,
	output logic      [31:0] ad_o,
	output logic             ad_en_b,
	output logic             par_o,
	output logic             par_en_b,
	output logic             devsel_b_o,
	output logic             trdy_b_o,
	output logic             stop_b_o,
	output logic             tctl_en_b,
	input  wire logic        serr_request,
	output logic             serr_o,
	output logic             serr_en_b,
	input  wire logic        master_req,
	output logic             bus_req_b,
	input  wire logic        master_abort_seen,
	input  wire logic        special_cycle,
	input  wire logic        target_abort_seen,
	input  wire logic        bar_window_hit,
	output logic             decode_fast,
	input  wire logic        strap_pin,
	output logic      [15:0] command_word
);
	pch_pkg::pch_state_t state_q, state_d;

	logic        frame_idle_q;
	logic [5:0]  idx_q;
	logic        rd_q;
	logic [15:0] cmd_q;
	logic [31:0] ad_q, ad_d;
	logic        ad_en_b_q, ad_en_b_d;
	logic        par_q, par_en_b_q, par_en_b_d;
	logic        devsel_b_q, trdy_b_q, stop_b_q, handshake_b_d;
	logic        tctl_en_b_q, tctl_en_b_d;
	logic        serr_o_q, serr_en_b_q;
	logic        bus_req_b_q;
	logic        decode_fast_q;

	logic        addr_phase;
	logic        is_cfg;
	logic        cfg_hit;
	logic [2:0]  func_num;
	logic        data_done;
	logic        wr_strobe;
	logic        hit_cmd;
	logic [15:0] cmd_d;
	logic [2:0]  flag_set;
	logic [2:0]  flag_clr;
	logic [2:0]  flags;
	logic        fast_bus_capable;
	logic [15:0] status_word;
	logic [31:0] rd_data;

	// Address phase: first cycle with FRAME# low after an idle bus
	assign addr_phase = frame_idle_q && !frame_b_i && (state_q == pch_pkg::PCH_IDLE);
	assign func_num   = ad_i[pch_pkg::ADDR_FUNC_MSB:pch_pkg::ADDR_FUNC_LSB];
	assign is_cfg     = (cbe_b_i == pch_pkg::CMD_CFG_READ) || (cbe_b_i == pch_pkg::CMD_CFG_WRITE);
	// Only function 0 of a type 0 cycle is claimed
	assign cfg_hit    = addr_phase && idsel && is_cfg && (ad_i[1:0] == pch_pkg::ADDR_TYPE0)
	                    && (func_num == pch_pkg::FUNC_ZERO);
	assign data_done  = (state_q == pch_pkg::PCH_ACK) && !irdy_b_i;
	assign wr_strobe  = data_done && !rd_q;
	assign hit_cmd    = idx_q == pch_pkg::IDX_CMD_STATUS;

	// Command word: only the documented control bits take writes
	assign cmd_d[7:0]  = (wr_strobe && hit_cmd && !cbe_b_i[0])
	                     ? (ad_i[7:0] & pch_pkg::CMD_WRITE_MASK[7:0]) : cmd_q[7:0];
	assign cmd_d[15:8] = (wr_strobe && hit_cmd && !cbe_b_i[1])
	                     ? (ad_i[15:8] & pch_pkg::CMD_WRITE_MASK[15:8]) : cmd_q[15:8];

	// Error events; SERR flag follows the real pin drive, not the request
	assign flag_set = {!serr_en_b_q, master_abort_seen && !special_cycle, target_abort_seen};
	// Write-one-to-clear, only through the top status byte lane
	assign flag_clr = (wr_strobe && hit_cmd && !cbe_b_i[3])
	                  ? ad_i[pch_pkg::STAT_FLAG_MSB:pch_pkg::STAT_FLAG_LSB] : 3'h0;

	// Status word assembled from constants, flags and strap
	assign status_word = {1'h0, flags, 1'h0, pch_pkg::DECODE_MEDIUM, 3'h0,
	                      fast_bus_capable, pch_pkg::CAP_PRESENT, 4'h0};

	// Read mux; unimplemented words in the space still answer, as zero
	assign rd_data = (idx_q == pch_pkg::IDX_IDENT) ? {CHIP_NUMBER, MAKER_CODE} :
	                 hit_cmd                       ? {status_word, cmd_q} :
	                                                 32'h0000_0000;

	// Sequencer next state and target pin values
	always_comb begin
		state_d       = state_q;
		ad_d          = ad_q;
		ad_en_b_d     = 1'h1;
		par_en_b_d    = 1'h1;
		handshake_b_d = 1'h1;
		tctl_en_b_d   = 1'h1;
		case (state_q)
			pch_pkg::PCH_IDLE: begin
				if (cfg_hit) begin
					state_d = pch_pkg::PCH_DECODE;
				end
			end
			pch_pkg::PCH_DECODE: begin
				// One decode cycle gives medium Decode_speed_field
				state_d       = pch_pkg::PCH_ACK;
				handshake_b_d = 1'h0;
				tctl_en_b_d   = 1'h0;
				ad_d          = rd_data;
				ad_en_b_d     = !rd_q;
			end
			pch_pkg::PCH_ACK: begin
				tctl_en_b_d = 1'h0;
				if (data_done) begin
					// Drive the strobes high for a cycle before letting go
					state_d    = pch_pkg::PCH_TURN;
					par_en_b_d = !rd_q;
				end else begin
					handshake_b_d = 1'h0;
					ad_en_b_d     = !rd_q;
				end
			end
			pch_pkg::PCH_TURN: begin
				state_d = pch_pkg::PCH_IDLE;
			end
			default: begin
				state_d = pch_pkg::PCH_IDLE;
			end
		endcase
	end

	// Sequencer and address capture
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state_q      <= pch_pkg::PCH_IDLE;
			frame_idle_q <= 1'h1;
			idx_q        <= 6'h00;
			rd_q         <= 1'h0;
		end else begin
			state_q      <= state_d;
			frame_idle_q <= frame_b_i;
			if (cfg_hit) begin
				idx_q <= ad_i[pch_pkg::ADDR_IDX_MSB:pch_pkg::ADDR_IDX_LSB];
				rd_q  <= cbe_b_i == pch_pkg::CMD_CFG_READ;
			end
		end
	end

	// Target pins; STOP# with TRDY# keeps every access to one doubleword
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ad_q        <= 32'h0000_0000;
			ad_en_b_q   <= 1'h1;
			par_q       <= 1'h0;
			par_en_b_q  <= 1'h1;
			devsel_b_q  <= 1'h1;
			trdy_b_q    <= 1'h1;
			stop_b_q    <= 1'h1;
			tctl_en_b_q <= 1'h1;
		end else begin
			ad_q        <= ad_d;
			ad_en_b_q   <= ad_en_b_d;
			par_q       <= ^{ad_q, cbe_b_i};
			par_en_b_q  <= par_en_b_d;
			devsel_b_q  <= handshake_b_d;
			trdy_b_q    <= handshake_b_d;
			stop_b_q    <= handshake_b_d;
			tctl_en_b_q <= tctl_en_b_d;
		end
	end

	// Control and side-band outputs
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cmd_q         <= pch_pkg::CMD_RESET;
			serr_o_q      <= 1'h0;
			serr_en_b_q   <= 1'h1;
			bus_req_b_q   <= 1'h1;
			decode_fast_q <= 1'h0;
		end else begin
			cmd_q         <= cmd_d;
			serr_o_q      <= 1'h0;
			serr_en_b_q   <= !(serr_request && cmd_q[pch_pkg::CMD_SYS_ERR_DRV]);
			bus_req_b_q   <= !(master_req && cmd_q[pch_pkg::CMD_BUS_MASTER]);
			decode_fast_q <= bar_window_hit;
		end
	end

	pch_sticky u_sticky (
		.mclk  (mclk),
		.rst_b (rst_b),
		.set   (flag_set),
		.clr   (flag_clr),
		.flags (flags)
	);

	pch_strap u_strap (
		.mclk             (mclk),
		.rst_b            (rst_b),
		.strap_pin        (strap_pin),
		.fast_bus_capable (fast_bus_capable)
	);

	assign ad_o         = ad_q;
	assign ad_en_b      = ad_en_b_q;
	assign par_o        = par_q;
	assign par_en_b     = par_en_b_q;
	assign devsel_b_o   = devsel_b_q;
	assign trdy_b_o     = trdy_b_q;
	assign stop_b_o     = stop_b_q;
	assign tctl_en_b    = tctl_en_b_q;
	assign serr_o       = serr_o_q;
	assign serr_en_b    = serr_en_b_q;
	assign bus_req_b    = bus_req_b_q;
	assign decode_fast  = decode_fast_q;
	assign command_word = cmd_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	// Claimed cycles: DEVSEL# two edges after the address, never one
	a_claim_medium: assert property (cfg_hit |=> devsel_b_q ##1 !devsel_b_q)
		else $error("claimed config cycle not acknowledged with medium timing");

	// Other functions never see DEVSEL#
	a_func_ignored: assert property (addr_phase && idsel && is_cfg && func_num != 3'h0
		|=> devsel_b_q [*4])
		else $error("DEVSEL asserted for a nonzero function");

	// Identification read returns the fixed codes
	a_ident_read: assert property (state_q == pch_pkg::PCH_ACK && rd_q && idx_q == 6'h00
		|-> ad_q == {CHIP_NUMBER, MAKER_CODE} && !ad_en_b_q)
		else $error("identification word read wrong");

	// Pin drive of SERR# always lands in the flag
	a_serr_flag_set: assert property (!serr_en_b_q |=> status_word[14])
		else $error("system error flag not set after SERR drive");

	a_mabort_set: assert property (master_abort_seen && !special_cycle |=> status_word[13])
		else $error("master abort flag not set");

	a_tabort_set: assert property (target_abort_seen |=> status_word[12])
		else $error("target abort flag not set");

	// Fixed and reserved status bits
	a_status_fixed: assert property (status_word[10:9] == 2'h1 && status_word[4] && !status_word[15]
		&& !status_word[11] && status_word[8:6] == 3'h0 && status_word[3:0] == 4'h0)
		else $error("fixed status bits wrong");

	// The edge just after reset sees the reset clear, not a capture
	a_strap_stable: assert property ($past(rst_b) && status_word[5] != $past(status_word[5])
		|-> $past(u_strap.take))
		else $error("speed capability changed after capture");

	a_serr_gated: assert property (!serr_en_b_q |-> $past(cmd_q[8]) && $past(serr_request))
		else $error("SERR driven while disabled");

	a_master_gated: assert property (!bus_req_b_q |-> $past(cmd_q[2]))
		else $error("bus request while mastering disabled");

	a_clear_one: assert property (wr_strobe && hit_cmd && !cbe_b_i[3] && ad_i[30] && serr_en_b_q
		|=> !status_word[14])
		else $error("system error flag not cleared by write of one");

	a_reset_values: assert property (disable iff (1'b0) !rst_b |=> cmd_q == 16'h0000 && flags == 3'h0)
		else $error("reset values wrong");

	a_fast_decode: assert property (bar_window_hit |=> decode_fast_q)
		else $error("fast decode not selected for window hit");

	// Strobes park high for one cycle while their enable still drives
	a_turn_release: assert property (state_q == pch_pkg::PCH_TURN
		|-> devsel_b_q && trdy_b_q && stop_b_q && !tctl_en_b_q)
		else $error("target strobes not parked high before release");

	a_read_parity: assert property (data_done && rd_q |=> !par_en_b_q ##1 par_en_b_q)
		else $error("parity enable wrong after read data phase");

	// Writes never turn the AD drivers on
	a_write_quiet: assert property (state_q == pch_pkg::PCH_ACK && !rd_q |-> ad_en_b_q)
		else $error("AD driven during a write");

endmodule

/* testbench/pch_host_model.sv */
// Host bridge model issuing single configuration cycles
`timescale 1ns/100ps
module pch_host_model (
	input  wire logic        mclk,
	input  wire logic [31:0] ad_o,
	input  wire logic        ad_en_b,
	input  wire logic        trdy_b_o,
	output logic             idsel,
	output logic             frame_b,
	output logic             irdy_b,
	output logic      [3:0]  cbe_b,
	output logic      [31:0] ad_bus
);
	logic [31:0] drv_q;

	// Wire level; released lines show the inverse, never a stale copy
	assign ad_bus = (ad_en_b === 1'b0) ? ad_o : drv_q;

	initial begin
		idsel = 1'b0;
		frame_b = 1'b1;
		irdy_b = 1'b1;
		cbe_b = 4'hF;
		drv_q = 32'h0;
	end

	// One doubleword; stops waiting after six edges, as a master abort
	task automatic cfg(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
		input logic [3:0] be_b, output logic [31:0] rdata, output logic hit);
		int n;
		@(negedge mclk);
		idsel = 1'b1;
		frame_b = 1'b0;
		cbe_b = wr ? 4'hB : 4'hA;
		drv_q = addr;
		@(negedge mclk);
		idsel = 1'b0;
		frame_b = 1'b1;
		irdy_b = 1'b0;
		cbe_b = be_b;
		drv_q = wr ? wdata : ~addr;
		hit = 1'b0;
		rdata = 32'h0;
		for (n = 0; n < 6 && !hit; n++) begin
			@(posedge mclk);
			if (trdy_b_o === 1'b0) begin
				hit = 1'b1;
				rdata = ad_bus;
			end
		end
		@(negedge mclk);
		irdy_b = 1'b1;
		cbe_b = 4'hF;
		drv_q = ~drv_q;
		// Idle gap keeps the minimum spacing between address phases
		repeat (3) @(negedge mclk);
	endtask
endmodule

/* testbench/tb_pci_config_header_status.sv */
// Self-checking bench for the configuration header and status block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin mismatches++; \
	$display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module tb_pci_config_header_status;
	localparam logic [15:0] CHIP  = 16'h3C71; // Arbitrary value
	localparam logic [15:0] MAKER = 16'h6B29; // Arbitrary value
	localparam logic [31:0] IDENT = {CHIP, MAKER};
	logic        mclk, rst_b, serr_request, master_req, master_abort_seen;
	logic        special_cycle, target_abort_seen, bar_window_hit, strap_pin, hit;
	logic [31:0] rd;
	wire         idsel, frame_b, irdy_b, ad_en_b, par_o, par_en_b, devsel_b_o, trdy_b_o;
	wire         stop_b_o, tctl_en_b, serr_o, serr_en_b, bus_req_b, decode_fast;
	wire  [3:0]  cbe_b;
	wire  [31:0] ad_bus, ad_o;
	wire  [15:0] command_word;
	int          mismatches, num_checks, cycles;

	pch_config_header #(.CHIP_NUMBER(CHIP), .MAKER_CODE(MAKER)) i_dut (
		.mclk(mclk), .rst_b(rst_b), .idsel(idsel), .frame_b_i(frame_b), .irdy_b_i(irdy_b),
		.cbe_b_i(cbe_b), .ad_i(ad_bus), .ad_o(ad_o), .ad_en_b(ad_en_b), .par_o(par_o),
		.par_en_b(par_en_b), .devsel_b_o(devsel_b_o), .trdy_b_o(trdy_b_o), .stop_b_o(stop_b_o),
		.tctl_en_b(tctl_en_b), .serr_request(serr_request), .serr_o(serr_o), .serr_en_b(serr_en_b),
		.master_req(master_req), .bus_req_b(bus_req_b), .master_abort_seen(master_abort_seen),
		.special_cycle(special_cycle), .target_abort_seen(target_abort_seen),
		.bar_window_hit(bar_window_hit), .decode_fast(decode_fast), .strap_pin(strap_pin),
		.command_word(command_word));

	pch_host_model i_host (.mclk(mclk), .ad_o(ad_o), .ad_en_b(ad_en_b), .trdy_b_o(trdy_b_o),
		.idsel(idsel), .frame_b(frame_b), .irdy_b(irdy_b), .cbe_b(cbe_b), .ad_bus(ad_bus));

	always #25 mclk = ~mclk;

	// Cycle ceiling well above the few hundred the tests need
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			conclude();
		end
	end

	// Status half with strap tied high
	function automatic logic [15:0] stat(input logic s, input logic m, input logic t);
		return {1'b0, s, m, t, 1'b0, pch_pkg::DECODE_MEDIUM, 3'h0, 1'b1, pch_pkg::CAP_PRESENT, 4'h0};
	endfunction

	task automatic rd_cfg(input logic [31:0] a);
		i_host.cfg(1'b0, a, 32'h0, 4'h0, rd, hit);
	endtask

	task automatic wr_cfg(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
		i_host.cfg(1'b1, a, d, be, rd, hit);
	endtask

	task automatic t_reset;
		`CHK("command_word", 16'h0000, command_word)
		`CHK("serr_en_b", 1'b1, serr_en_b)
		`CHK("bus_req_b", 1'b1, bus_req_b)
		rd_cfg(32'h4);
		`CHK("status", stat(0, 0, 0), rd[31:16])
		`CHK("command half", 16'h0000, rd[15:0])
		$display("test reset done");
	endtask

	task automatic t_ident;
		rd_cfg(32'h0);
		`CHK("ident", IDENT, rd)
		wr_cfg(32'h0, 32'hFFFF_FFFF, 4'h0);
		rd_cfg(32'h0);
		`CHK("ident after write", IDENT, rd)
		rd_cfg(32'hFC);
		`CHK("last dword hit", 1'b1, hit)
		$display("test ident done");
	endtask

	// Target pins of one read and one write, looked at on the falling edges
	task automatic t_pins;
		fork
			rd_cfg(32'h0);
			begin
				repeat (3) @(negedge mclk);
				`CHK("devsel on", 1'b0, devsel_b_o)
				`CHK("stop on", 1'b0, stop_b_o)
				`CHK("tctl on", 1'b0, tctl_en_b)
				`CHK("ad drive", 1'b0, ad_en_b)
				`CHK("ad data", IDENT, ad_o)
				@(negedge mclk);
				`CHK("devsel off", 1'b1, devsel_b_o)
				`CHK("stop off", 1'b1, stop_b_o)
				`CHK("tctl turn", 1'b0, tctl_en_b)
				`CHK("ad release", 1'b1, ad_en_b)
				`CHK("par drive", 1'b0, par_en_b)
				`CHK("par value", ^IDENT, par_o)
				@(negedge mclk);
				`CHK("tctl off", 1'b1, tctl_en_b)
				`CHK("par off", 1'b1, par_en_b)
			end
		join
		fork
			wr_cfg(32'h8, 32'hFFFF_FFFF, 4'h0);
			begin
				repeat (3) @(negedge mclk);
				`CHK("write ack", 1'b0, trdy_b_o)
				`CHK("write no drive", 1'b1, ad_en_b)
				@(negedge mclk);
				`CHK("write no par", 1'b1, par_en_b)
			end
		join
		rd_cfg(32'h8);
		`CHK("unused word hit", 1'b1, hit)
		`CHK("unused word", 32'h0000_0000, rd)
		$display("test pins done");
	endtask

	task automatic t_function;
		for (int f = 1; f < 8; f++) begin
			rd_cfg({21'h0, f[2:0], 8'h04});
			`CHK("other function hit", 1'b0, hit)
		end
		// Type 1 cycles belong to bridges, never to this target
		rd_cfg(32'h0000_0005);
		`CHK("type 1 hit", 1'b0, hit)
		$display("test function done");
	endtask

	task automatic t_command;
		wr_cfg(32'h4, 32'hFFFF_FFFF, 4'hC);
		`CHK("command_word", pch_pkg::CMD_WRITE_MASK, command_word)
		master_req = 1'b1;
		@(negedge mclk);
		`CHK("bus_req_b on", 1'b0, bus_req_b)
		master_req = 1'b0;
		wr_cfg(32'h4, 32'h0, 4'hC);
		master_req = 1'b1;
		@(negedge mclk);
		`CHK("bus_req_b off", 1'b1, bus_req_b)
		master_req = 1'b0;
		$display("test command done");
	endtask

	task automatic t_serr;
		serr_request = 1'b1;
		@(negedge mclk);
		`CHK("serr gated", 1'b1, serr_en_b)
		serr_request = 1'b0;
		rd_cfg(32'h4);
		`CHK("flag idle", stat(0, 0, 0), rd[31:16])
		wr_cfg(32'h4, 32'h100, 4'hC);
		serr_request = 1'b1;
		@(negedge mclk);
		`CHK("serr driven", 1'b0, serr_en_b)
		`CHK("serr value", 1'b0, serr_o)
		serr_request = 1'b0;
		@(negedge mclk);
		rd_cfg(32'h4);
		`CHK("serr flag", stat(1, 0, 0), rd[31:16])
		wr_cfg(32'h4, 32'h0, 4'h7);
		rd_cfg(32'h4);
		`CHK("zero write", stat(1, 0, 0), rd[31:16])
		wr_cfg(32'h4, 32'h4000_0000, 4'h7);
		rd_cfg(32'h4);
		`CHK("serr cleared", stat(0, 0, 0), rd[31:16])
		$display("test serr done");
	endtask

	task automatic t_abort;
		special_cycle = 1'b1;
		master_abort_seen = 1'b1;
		@(negedge mclk);
		special_cycle = 1'b0;
		master_abort_seen = 1'b0;
		rd_cfg(32'h4);
		`CHK("special abort", stat(0, 0, 0), rd[31:16])
		master_abort_seen = 1'b1;
		@(negedge mclk);
		master_abort_seen = 1'b0;
		target_abort_seen = 1'b1;
		@(negedge mclk);
		target_abort_seen = 1'b0;
		rd_cfg(32'h4);
		`CHK("aborts", stat(0, 1, 1), rd[31:16])
		wr_cfg(32'h4, 32'h2000_0000, 4'h7);
		rd_cfg(32'h4);
		`CHK("master clr", stat(0, 0, 1), rd[31:16])
		wr_cfg(32'h4, 32'hFFFF_0000, 4'h3);
		rd_cfg(32'h4);
		`CHK("target clr", stat(0, 0, 0), rd[31:16])
		$display("test abort done");
	endtask

	task automatic t_decode;
		bar_window_hit = 1'b1;
		@(negedge mclk);
		`CHK("fast", 1'b1, decode_fast)
		bar_window_hit = 1'b0;
		@(negedge mclk);
		`CHK("medium", 1'b0, decode_fast)
		$display("test decode done");
	endtask

	// Reset in mid-run clears command and flags, and catches the strap again
	task automatic t_rst_mid;
		wr_cfg(32'h4, 32'hFFFF_FFFF, 4'hC);
		target_abort_seen = 1'b1;
		@(negedge mclk);
		target_abort_seen = 1'b0;
		rd_cfg(32'h4);
		`CHK("before reset", stat(0, 0, 1), rd[31:16])
		`CHK("command before reset", pch_pkg::CMD_WRITE_MASK, rd[15:0])
		rst_b = 1'b0;
		strap_pin = 1'b0;
		repeat (2) @(negedge mclk);
		`CHK("command in reset", 16'h0000, command_word)
		rst_b = 1'b1;
		repeat (5) @(negedge mclk);
		rd_cfg(32'h4);
		`CHK("flags after reset", 3'h0, rd[30:28])
		`CHK("strap low", 1'b0, rd[21])
		`CHK("command after reset", 16'h0000, rd[15:0])
		$display("test mid reset done");
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		{mclk, rst_b, serr_request, master_req, master_abort_seen} = 5'h0;
		{special_cycle, target_abort_seen, bar_window_hit} = 3'h0;
		strap_pin = 1'b1;
		{mismatches, num_checks, cycles} = {32'h0, 32'h0, 32'h0};
		repeat (4) @(negedge mclk);
		rst_b = 1'b1;
		repeat (5) @(negedge mclk);
		t_reset();
		t_ident();
		t_pins();
		t_function();
		t_command();
		t_serr();
		t_abort();
		t_decode();
		t_rst_mid();
		conclude();
	end
endmodule
